/* File: design/tcou_pkg.sv */
// Package: register map, field layout and constants of the timer compare output unit
// Contract
// - Upper write latches; lower write transfers both
// - Compare value reads direct, no latch
// - Force strobe acts on latch, no flag; code ignores it in PWM modes
// - Counter write blocks next tick matches
// - Output latch kept across mode changes
// - Action select applies immediately, unbuffered
// - New action governs from next match
// - Reset clears compare output latch
// - Nonzero action overrides port value on pin
// - Action select never touches capture logic
// - Action zero leaves latch unchanged
// - Counting depends only on mode bits; code counts alike in every mode
// - Action picks set, clear, toggle or polarity
// - Mode zero counts up and wraps
// - Overflow flag sets when counter becomes zero
// - Counter accepts writes any time
// - Equality sets match flag next tick
// - PWM buffers compare; normal writes direct
// - Match flag cleared by writing one
package tcou_pkg;

  // ****************************************************************
  // Register byte addresses
  // ****************************************************************
  localparam logic [7:0] TCOU_ADDR_CTRL     = 8'h00; // Mode, actions, direction bits
  localparam logic [7:0] TCOU_ADDR_FORCE    = 8'h04; // Force strobes, write-only
  localparam logic [7:0] TCOU_ADDR_FLAGS    = 8'h08; // Sticky flags, write one clears
  localparam logic [7:0] TCOU_ADDR_CNT_LO   = 8'h0C; // Counter lower byte
  localparam logic [7:0] TCOU_ADDR_CNT_HI   = 8'h10; // Counter upper byte
  localparam logic [7:0] TCOU_ADDR_CMPA_LO  = 8'h14; // Channel A lower byte
  localparam logic [7:0] TCOU_ADDR_CMPA_HI  = 8'h18; // Channel A upper byte
  localparam logic [7:0] TCOU_ADDR_CMPB_LO  = 8'h1C; // Channel B lower byte
  localparam logic [7:0] TCOU_ADDR_CMPB_HI  = 8'h20; // Channel B upper byte
  localparam logic [7:0] TCOU_ADDR_PORT     = 8'h24; // Read-back of pin values

  // ****************************************************************
  // Control field positions
  // ****************************************************************
  localparam int TCOU_CTRL_MODE_LSB = 0;  // Four mode bits
  localparam int TCOU_CTRL_ACTA_LSB = 4;  // Two action bits, channel A
  localparam int TCOU_CTRL_ACTB_LSB = 6;  // Two action bits, channel B
  localparam int TCOU_CTRL_DIRA_BIT = 8;  // Pin direction, channel A
  localparam int TCOU_CTRL_DIRB_BIT = 9;  // Pin direction, channel B
  localparam int TCOU_FLAG_MA_BIT   = 0;  // Match flag A
  localparam int TCOU_FLAG_MB_BIT   = 1;  // Match flag B
  localparam int TCOU_FLAG_OV_BIT   = 2;  // Overflow flag
  localparam int TCOU_FORCE_A_BIT   = 0;  // Force strobe A
  localparam int TCOU_FORCE_B_BIT   = 1;  // Force strobe B

  // ****************************************************************
  // Values
  // ****************************************************************
  localparam logic [3:0]  TCOU_MODE_NORMAL = 4'h0;    // Plain up count
  localparam logic [3:0]  TCOU_MODE_CTC_A  = 4'h4;    // Non-PWM; counter still wraps, no clear on match
  localparam logic [3:0]  TCOU_MODE_CTC_I  = 4'hC;    // Non-PWM; counter still wraps, no clear on match
  localparam logic [15:0] TCOU_CNT_MAX     = 16'hFFFF;
  localparam logic [15:0] TCOU_CNT_BOTTOM  = 16'h0000;
  localparam logic [15:0] TCOU_CNT_STEP    = 16'h0001;
  localparam logic [7:0]  TCOU_BYTE_ZERO   = 8'h00;

  // Output action encodings
  typedef enum logic [1:0] {
    TCOU_ACT_NONE   = 2'h0,
    TCOU_ACT_TOGGLE = 2'h1,
    TCOU_ACT_CLEAR  = 2'h2,
    TCOU_ACT_SET    = 2'h3
  } tcou_act_t;

  // True for modes that are neither normal nor clear-on-match
  function automatic logic tcou_is_pwm(input logic [3:0] mode);
    return !((mode == TCOU_MODE_NORMAL) || (mode == TCOU_MODE_CTC_A) ||
             (mode == TCOU_MODE_CTC_I));
  endfunction

endpackage

/* File: design/tcou_ch_if.sv */
// Interface: one compare channel's control and events between top and channel
`timescale 1ns/1ps
interface tcou_ch_if;
  logic [1:0] action;    // Output action select
  logic       pwm_mode;  // Current mode is PWM
  logic       match;     // Qualified match this tick
  logic       force_hit; // Force strobe accepted
  logic       top_hit;   // Counter at TOP this tick
  logic       latch;     // Compare output latch value

  modport top (output action, pwm_mode, match, force_hit, top_hit, input latch);
  modport chan (input action, pwm_mode, match, force_hit, top_hit, output latch);
endinterface

/* File: design/tcou_chan.sv */
// Module: compare output latch of one channel
`timescale 1ns/1ps
module tcou_chan
  import tcou_pkg::*;
(
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic srst_i,
  // Control from the top
  tcou_ch_if.chan   ch
);

  logic latch_ff;  // Compare output latch
  logic nxt_latch; // Next latch value

  // ****************************************************************
  // Latch update
  // ****************************************************************
  // Action read live each event, so a new select acts at once
  always_comb begin
    nxt_latch = latch_ff;
    if (!ch.pwm_mode && (ch.match || ch.force_hit)) begin
      unique case (ch.action)
        TCOU_ACT_NONE:   nxt_latch = latch_ff;
        TCOU_ACT_TOGGLE: nxt_latch = !latch_ff;
        TCOU_ACT_CLEAR:  nxt_latch = 1'b0;
        TCOU_ACT_SET:    nxt_latch = 1'b1;
      endcase
    end else if (ch.pwm_mode && ch.action[1]) begin
      // PWM: match drives one level, TOP the other; bit 0 inverts
      if (ch.top_hit) begin
        nxt_latch = ch.action[0];
      end else if (ch.match) begin
        nxt_latch = !ch.action[0];
      end
    end
  end

  // Mode changes do not touch the latch; only reset does
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      latch_ff <= 1'b0;
    end else begin
      latch_ff <= nxt_latch;
    end
  end

  assign ch.latch = latch_ff;

endmodule

/* File: design/tcou_top.sv */
// Module: 16-bit timer compare output unit with APB register access
//
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/1ps
module tcou_top
  import tcou_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Timer tick enable from prescaler
  input  wire logic        tick_i,
  // General port values for the two pins
  input  wire logic [1:0]  port_value_i,
  // Pins
  output logic      [1:0]  pin_value_o,
  output logic      [1:0]  pin_oe_o,
  // Status
  output logic      [15:0] counter_value_o,
  output logic      [2:0]  flags_o
);

  // ****************************************************************
  // State
  // ****************************************************************
  logic [15:0] cnt_ff;          // Counter value
  logic [15:0] cmp_a_ff;        // Active compare A
  logic [15:0] cmp_b_ff;        // Active compare B
  logic [15:0] buf_a_ff;        // PWM buffer A
  logic [15:0] buf_b_ff;        // PWM buffer B
  logic [7:0]  hi_latch_ff;     // Shared upper-byte latch
  logic [3:0]  mode_ff;         // Waveform mode select
  logic [1:0]  act_a_ff;        // Output action A
  logic [1:0]  act_b_ff;        // Output action B
  logic [1:0]  dir_ff;          // Pin direction bits
  logic        blk_ff;          // Block matches on next tick
  logic        flag_ma_ff;      // Compare match flag A
  logic        flag_mb_ff;      // Compare match flag B
  logic        flag_ov_ff;      // Overflow flag
  logic        eq_a_ff;         // Equality seen, flag on next tick
  logic        eq_b_ff;         // Equality seen, flag on next tick
  logic [31:0] prdata_ff;       // Read data register
  logic        pready_ff;       // Ready register
  logic        pslverr_ff;      // Error register
  logic [1:0]  pin_value_ff;    // Pin value register
  logic [1:0]  pin_oe_ff;       // Pin enable register

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  logic        acc;             // Access phase, taken this edge
  logic        wr;              // Write taken
  logic        rd;              // Read taken
  logic [7:0]  wbyte;           // Low write byte
  logic        wr_cnt;          // Any counter byte write
  logic        pwm;             // PWM mode in force
  logic        top_hit;         // Counter at MAX
  logic        eq_a;            // Raw equality A
  logic        eq_b;            // Raw equality B
  logic        match_a;         // Qualified match A
  logic        match_b;         // Qualified match B
  logic        known;           // Address is mapped
  logic        frc_a;           // Force A accepted
  logic        frc_b;           // Force B accepted

  // One wait state: setup, then access with pready registered
  assign acc    = psel_i && penable_i && pready_ff;
  assign wr     = acc && pwrite_i;
  assign rd     = acc && !pwrite_i;
  assign wbyte  = pwdata_i[7:0];
  assign wr_cnt = wr && ((paddr_i == TCOU_ADDR_CNT_LO) || (paddr_i == TCOU_ADDR_CNT_HI));
  assign pwm    = tcou_is_pwm(mode_ff);
  assign top_hit = (cnt_ff == TCOU_CNT_MAX);

  // Known address check, used only by the error response
  function automatic logic tcou_mapped(input logic [7:0] a);
    return (a == TCOU_ADDR_CTRL) || (a == TCOU_ADDR_FORCE) || (a == TCOU_ADDR_FLAGS) ||
           (a == TCOU_ADDR_CNT_LO) || (a == TCOU_ADDR_CNT_HI) ||
           (a == TCOU_ADDR_CMPA_LO) || (a == TCOU_ADDR_CMPA_HI) ||
           (a == TCOU_ADDR_CMPB_LO) || (a == TCOU_ADDR_CMPB_HI) ||
           (a == TCOU_ADDR_PORT);
  endfunction

  assign known = tcou_mapped(paddr_i);

  // ****************************************************************
  // Comparators
  // ****************************************************************
  assign eq_a    = (cnt_ff == cmp_a_ff);
  assign eq_b    = (cnt_ff == cmp_b_ff);
  assign match_a = tick_i && eq_a && !blk_ff;
  assign match_b = tick_i && eq_b && !blk_ff;
  assign frc_a   = wr && (paddr_i == TCOU_ADDR_FORCE) && wbyte[TCOU_FORCE_A_BIT] && !pwm;
  assign frc_b   = wr && (paddr_i == TCOU_ADDR_FORCE) && wbyte[TCOU_FORCE_B_BIT] && !pwm;

  // ****************************************************************
  // APB handshake
  // ****************************************************************
  // Ready pulses one cycle into each access phase
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= psel_i && penable_i && !pready_ff;
      pslverr_ff <= psel_i && penable_i && !pready_ff && !known;
    end
  end

  // Read data, captured one cycle ahead of the taking edge
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      prdata_ff <= 32'h0000_0000;
    end else begin
      prdata_ff <= 32'h0000_0000;
      if (psel_i && penable_i && !pready_ff && !pwrite_i) begin
        unique case (paddr_i)
          TCOU_ADDR_CTRL:    prdata_ff[9:0] <= {dir_ff, act_b_ff, act_a_ff, mode_ff};
          TCOU_ADDR_FLAGS:   prdata_ff[2:0] <= {flag_ov_ff, flag_mb_ff, flag_ma_ff};
          TCOU_ADDR_CNT_LO:  prdata_ff[7:0] <= cnt_ff[7:0];
          TCOU_ADDR_CNT_HI:  prdata_ff[7:0] <= cnt_ff[15:8];
          // Compare registers read straight back, no shared latch
          TCOU_ADDR_CMPA_LO: prdata_ff[7:0] <= pwm ? buf_a_ff[7:0] : cmp_a_ff[7:0];
          TCOU_ADDR_CMPA_HI: prdata_ff[7:0] <= pwm ? buf_a_ff[15:8] : cmp_a_ff[15:8];
          TCOU_ADDR_CMPB_LO: prdata_ff[7:0] <= pwm ? buf_b_ff[7:0] : cmp_b_ff[7:0];
          TCOU_ADDR_CMPB_HI: prdata_ff[7:0] <= pwm ? buf_b_ff[15:8] : cmp_b_ff[15:8];
          TCOU_ADDR_PORT:    prdata_ff[3:0] <= {pin_oe_ff, pin_value_ff};
          default:           prdata_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ****************************************************************
  // Control register
  // ****************************************************************
  // Actions take effect the cycle after the write, no buffering
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      mode_ff  <= TCOU_MODE_NORMAL;
      act_a_ff <= TCOU_ACT_NONE;
      act_b_ff <= TCOU_ACT_NONE;
      dir_ff   <= 2'h0;
    end else if (wr && (paddr_i == TCOU_ADDR_CTRL)) begin
      mode_ff  <= pwdata_i[TCOU_CTRL_MODE_LSB +: 4];
      act_a_ff <= pwdata_i[TCOU_CTRL_ACTA_LSB +: 2];
      act_b_ff <= pwdata_i[TCOU_CTRL_ACTB_LSB +: 2];
      dir_ff   <= {pwdata_i[TCOU_CTRL_DIRB_BIT], pwdata_i[TCOU_CTRL_DIRA_BIT]};
    end
  end

  // ****************************************************************
  // Compare value registers
  // ****************************************************************
  // Upper write only loads the latch; lower write commits all 16 bits
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      hi_latch_ff <= TCOU_BYTE_ZERO;
    end else if (wr && ((paddr_i == TCOU_ADDR_CMPA_HI) || (paddr_i == TCOU_ADDR_CMPB_HI) ||
                        (paddr_i == TCOU_ADDR_CNT_HI))) begin
      hi_latch_ff <= wbyte;
    end
  end

  // Normal and CTC write the active copy; PWM writes the buffer
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cmp_a_ff <= TCOU_CNT_BOTTOM;
      cmp_b_ff <= TCOU_CNT_BOTTOM;
      buf_a_ff <= TCOU_CNT_BOTTOM;
      buf_b_ff <= TCOU_CNT_BOTTOM;
    end else begin
      if (wr && (paddr_i == TCOU_ADDR_CMPA_LO)) begin
        if (pwm) begin
          buf_a_ff <= {hi_latch_ff, wbyte};
        end else begin
          cmp_a_ff <= {hi_latch_ff, wbyte};
        end
      end
      if (wr && (paddr_i == TCOU_ADDR_CMPB_LO)) begin
        if (pwm) begin
          buf_b_ff <= {hi_latch_ff, wbyte};
        end else begin
          cmp_b_ff <= {hi_latch_ff, wbyte};
        end
      end
      // Buffers move to the active copy at TOP
      if (pwm && tick_i && top_hit) begin
        cmp_a_ff <= buf_a_ff;
        cmp_b_ff <= buf_b_ff;
      end
    end
  end

  // ****************************************************************
  // Counter
  // ****************************************************************
  // Neither mode nor actions enter here; counting is the same in every mode
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cnt_ff <= TCOU_CNT_BOTTOM;
    end else if (wr && (paddr_i == TCOU_ADDR_CNT_LO)) begin
      cnt_ff <= {hi_latch_ff, wbyte};
    end else if (tick_i) begin
      // Wraps MAX to BOTTOM; no clear in normal mode
      cnt_ff <= cnt_ff + TCOU_CNT_STEP;
    end
  end

  // Block holds from a counter write until the next tick is consumed
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      blk_ff <= 1'b0;
    end else if (wr_cnt) begin
      blk_ff <= 1'b1;
    end else if (tick_i) begin
      blk_ff <= 1'b0;
    end
  end

  // ****************************************************************
  // Flags
  // ****************************************************************
  // Match seen on one tick, flag set on the next
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      eq_a_ff <= 1'b0;
      eq_b_ff <= 1'b0;
    end else if (tick_i) begin
      eq_a_ff <= match_a;
      eq_b_ff <= match_b;
    end
  end

  // Set wins over a one-written clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      flag_ma_ff <= 1'b0;
      flag_mb_ff <= 1'b0;
      flag_ov_ff <= 1'b0;
    end else begin
      if (tick_i && eq_a_ff) begin
        flag_ma_ff <= 1'b1;
      end else if (wr && (paddr_i == TCOU_ADDR_FLAGS) && wbyte[TCOU_FLAG_MA_BIT]) begin
        flag_ma_ff <= 1'b0;
      end
      if (tick_i && eq_b_ff) begin
        flag_mb_ff <= 1'b1;
      end else if (wr && (paddr_i == TCOU_ADDR_FLAGS) && wbyte[TCOU_FLAG_MB_BIT]) begin
        flag_mb_ff <= 1'b0;
      end
      // Set as counter steps MAX to zero, like a 17th bit
      // Only a lower-byte commit moves the counter, so only it masks the wrap
      if (tick_i && top_hit && !(wr && (paddr_i == TCOU_ADDR_CNT_LO))) begin
        flag_ov_ff <= 1'b1;
      end else if (wr && (paddr_i == TCOU_ADDR_FLAGS) && wbyte[TCOU_FLAG_OV_BIT]) begin
        flag_ov_ff <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Channels and pin mux
  // ****************************************************************
  tcou_ch_if ch_a ();
  tcou_ch_if ch_b ();

  // Action bits reach the channel latches, the pin mux and the control read-back
  assign ch_a.action    = act_a_ff;
  assign ch_a.pwm_mode  = pwm;
  assign ch_a.match     = match_a;
  assign ch_a.force_hit = frc_a;
  assign ch_a.top_hit   = tick_i && top_hit;
  assign ch_b.action    = act_b_ff;
  assign ch_b.pwm_mode  = pwm;
  assign ch_b.match     = match_b;
  assign ch_b.force_hit = frc_b;
  assign ch_b.top_hit   = tick_i && top_hit;

  tcou_chan u_chan_a (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .ch     (ch_a.chan)
  );

  tcou_chan u_chan_b (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .ch     (ch_b.chan)
  );

  // Nonzero action hands the pin to the latch; direction stays with dir bit
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pin_value_ff <= 2'h0;
      pin_oe_ff    <= 2'h0;
    end else begin
      pin_value_ff[0] <= (act_a_ff != TCOU_ACT_NONE) ? ch_a.latch : port_value_i[0];
      pin_value_ff[1] <= (act_b_ff != TCOU_ACT_NONE) ? ch_b.latch : port_value_i[1];
      pin_oe_ff       <= dir_ff;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign prdata_o        = prdata_ff;
  assign pready_o        = pready_ff;
  assign pslverr_o       = pslverr_ff;
  assign pin_value_o     = pin_value_ff;
  assign pin_oe_o        = pin_oe_ff;
  assign counter_value_o = cnt_ff;
  assign flags_o         = {flag_ov_ff, flag_mb_ff, flag_ma_ff};

endmodule

/* File: bench/tcou_asserts.sv */
// Checker: port-level assertions for the timer compare output unit
`timescale 1ns/1ps
module tcou_asserts
  import tcou_pkg::*;
(
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        srst_i,
  // APB
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  // Timer and pins
  input wire logic        tick_i,
  input wire logic [1:0]  pin_oe_o,
  input wire logic [15:0] counter_value_o,
  input wire logic [2:0]  flags_o
);
  // ****************************************************************
  // Helpers
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  logic wr_taken; // Write accepted at this edge
  logic wr_cnt;   // Counter commit, lower byte
  assign wr_taken = psel_i & penable_i & pready_o & pwrite_i;
  assign wr_cnt   = wr_taken & (paddr_i == TCOU_ADDR_CNT_LO);

  // ****************************************************************
  // Assertions
  // ****************************************************************
  chk_ready_delay: assert property ($rose(penable_i) && psel_i |=> pready_o)
    else $error("pready not one cycle after access phase start");
  chk_err_ready: assert property (pslverr_o |-> pready_o)
    else $error("pslverr without pready");
  chk_rdata_idle: assert property (!pready_o |-> prdata_o == 32'h0)
    else $error("read data not zero outside answer");
  chk_cnt_hold: assert property (!tick_i && !wr_cnt |=> $stable(counter_value_o))
    else $error("counter moved without tick");
  chk_cnt_step: assert property (tick_i && !wr_cnt |=>
    counter_value_o == $past(counter_value_o) + TCOU_CNT_STEP)
    else $error("counter did not step by one");
  chk_ov_wrap: assert property (tick_i && !wr_cnt && counter_value_o == TCOU_CNT_MAX
    |=> flags_o[TCOU_FLAG_OV_BIT]) else $error("overflow flag missed at wrap");
  chk_ov_sticky: assert property (flags_o[TCOU_FLAG_OV_BIT] && !(wr_taken &&
    paddr_i == TCOU_ADDR_FLAGS && pwdata_i[TCOU_FLAG_OV_BIT]) |=> flags_o[TCOU_FLAG_OV_BIT])
    else $error("overflow flag lost");
  chk_ov_cause: assert property ($rose(flags_o[TCOU_FLAG_OV_BIT]) |->
    $past(tick_i) && $past(counter_value_o) == TCOU_CNT_MAX) else $error("overflow flag early");
  chk_flag_tick: assert property ($rose(flags_o[TCOU_FLAG_MA_BIT]) |-> $past(tick_i))
    else $error("match flag set off tick");
  chk_oe_hold: assert property (!(wr_taken && paddr_i == TCOU_ADDR_CTRL)
    |-> ##2 $stable(pin_oe_o)) else $error("pin enable moved without control write");
  // Main scenarios reached
  cov_ov: cover property ($rose(flags_o[TCOU_FLAG_OV_BIT]));
  cov_match: cover property ($rose(flags_o[TCOU_FLAG_MA_BIT]));
  cov_err: cover property (pslverr_o);
endmodule

bind tcou_top tcou_asserts i_chk (
  .clk_i(clk_i), .srst_i(srst_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .tick_i(tick_i), .pin_oe_o(pin_oe_o),
  .counter_value_o(counter_value_o), .flags_o(flags_o)
);

/* File: bench/tcou_pin_model.sv */
// Model: general port logic and pin wire beside the compare outputs
`timescale 1ns/1ps
module tcou_pin_model (
  // Clock
  input  wire logic       clk_i,
  // Port value set by software
  input  wire logic [1:0] port_set_i,
  // Drive from the timer
  input  wire logic [1:0] pin_value_i,
  input  wire logic [1:0] pin_oe_i,
  // Port value to the timer, resolved wire
  output logic      [1:0] port_value_o,
  output logic      [1:0] pin_level_o
);
  localparam logic [1:0] PULL_LEVEL = 2'h3; // Pull-up on undriven pins

  // Port output register, written like any port bit
  always_ff @(posedge clk_i) begin
    port_value_o <= port_set_i;
  end

  // Wire level: driven value where enabled, else the pull
  assign pin_level_o = (pin_oe_i & pin_value_i) | (~pin_oe_i & PULL_LEVEL);
endmodule

/* File: bench/tcou_tb_top.sv */
// Testbench: APB-driven tests of the timer compare output unit
`timescale 1ns/1ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin n_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tcou_tb_top
  import tcou_pkg::*;
;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic        clk_i, srst_i, psel_i, penable_i, pwrite_i, tick_i;
  logic        pready_o, pslverr_o, rerr;
  logic [7:0]  paddr_i;
  logic [31:0] pwdata_i, prdata_o, rdata;
  logic [1:0]  port_value_i, port_set, pin_value_o, pin_oe_o, pin_level;
  logic [15:0] counter_value_o;
  logic [2:0]  flags_o;
  int          n_errors, check_count;
  // Force sequence: set, clear, toggle, none, toggle, set
  localparam logic [11:0] ACTS    = 12'hD1B;
  localparam logic [5:0]  EXP_PIN = 6'h25; // Index 3 shows the port value

  tcou_top i_dut (
    .clk_i(clk_i), .srst_i(srst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .tick_i(tick_i),
    .port_value_i(port_value_i), .pin_value_o(pin_value_o), .pin_oe_o(pin_oe_o),
    .counter_value_o(counter_value_o), .flags_o(flags_o));
  tcou_pin_model i_pins (
    .clk_i(clk_i), .port_set_i(port_set), .pin_value_i(pin_value_o),
    .pin_oe_i(pin_oe_o), .port_value_o(port_value_i), .pin_level_o(pin_level));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  // One APB transfer; waits for pready, the watchdog ends a dead slave
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= w;
    paddr_i   <= a;
    pwdata_i  <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (pready_o !== 1'b1);
    rdata = prdata_o;
    rerr  = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  // Single-cycle tick pulses, then let registered outputs settle
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk_i);
      tick_i <= 1'b1;
      @(posedge clk_i);
      tick_i <= 1'b0;
    end
    repeat (2) @(posedge clk_i);
  endtask
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", check_count, n_errors);
    if ((n_errors == 0) && (check_count > 0)) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ****************************************************************
  // Clock, watchdog and tests
  // ****************************************************************
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // Tests need a few hundred cycles; this is ample
  initial begin
    #100000;
    n_errors++;
    give_verdict();
  end
  initial begin
    {srst_i, psel_i, penable_i, pwrite_i, tick_i} = 5'h10;
    {paddr_i, pwdata_i, port_set, n_errors, check_count} = '0;
    repeat (20) @(posedge clk_i);
    srst_i <= 1'b0;
    rd(TCOU_ADDR_FLAGS);
    `CHK(rdata, 32'h0)
    `CHK(pin_value_o, 2'h0)
    rd(8'h30);
    `CHK({rerr, rdata}, 33'h100000000)
    // Upper byte stays hidden until the lower byte commits
    wr(TCOU_ADDR_CMPB_HI, 32'hAB);
    rd(TCOU_ADDR_CMPB_HI);
    `CHK(rdata, 32'h0)
    wr(TCOU_ADDR_CMPB_LO, 32'hCD);
    rd(TCOU_ADDR_CMPB_LO);
    `CHK(rdata, 32'hCD)
    rd(TCOU_ADDR_CMPB_HI);
    `CHK(rdata, 32'hAB)
    // Force strobe through every action, pin A driven
    for (int i = 0; i < 6; i++) begin
      wr(TCOU_ADDR_CTRL, {22'h0, 4'h4, ACTS[2*i+:2], 4'h0});
      wr(TCOU_ADDR_FORCE, 32'h1);
      repeat (2) @(posedge clk_i);
      `CHK(pin_value_o[0], EXP_PIN[i])
      `CHK(pin_level[0], EXP_PIN[i])
      `CHK(flags_o, 3'h0)
    end
    wr(TCOU_ADDR_CTRL, 32'h134);
    repeat (2) @(posedge clk_i);
    `CHK(pin_value_o[0], 1'b1)
    // Normal counting, wrap, match toggle
    wr(TCOU_ADDR_CMPA_HI, 32'h0);
    wr(TCOU_ADDR_CMPA_LO, 32'h1);
    wr(TCOU_ADDR_CTRL, 32'h110);
    wr(TCOU_ADDR_CNT_HI, 32'hFF);
    wr(TCOU_ADDR_CNT_LO, 32'hFE);
    repeat (3) @(posedge clk_i);
    `CHK(counter_value_o, 16'hFFFE)
    ticks(2);
    `CHK(counter_value_o, 16'h0000)
    `CHK(flags_o, 3'h4)
    ticks(2);
    `CHK({pin_value_o[0], flags_o[0]}, 2'h0)
    ticks(1);
    `CHK(flags_o, 3'h5)
    wr(TCOU_ADDR_FLAGS, 32'h7);
    @(posedge clk_i);
    `CHK(flags_o, 3'h0)
    // Counter written equal to the compare value: that match is lost
    wr(TCOU_ADDR_CNT_HI, 32'h0);
    wr(TCOU_ADDR_CNT_LO, 32'h1);
    ticks(3);
    `CHK({pin_value_o[0], flags_o[0]}, 2'h0)
    // New action acts on the very next match
    wr(TCOU_ADDR_CTRL, 32'h130);
    wr(TCOU_ADDR_CNT_LO, 32'h0);
    ticks(2);
    `CHK(pin_value_o[0], 1'b1)
    rd(TCOU_ADDR_PORT);
    `CHK(rdata, 32'h5)
    // PWM: compare write parks in the buffer until TOP
    wr(TCOU_ADDR_CTRL, 32'h135);
    wr(TCOU_ADDR_CMPA_HI, 32'h0);
    wr(TCOU_ADDR_CMPA_LO, 32'h5);
    rd(TCOU_ADDR_CMPA_LO);
    `CHK(rdata, 32'h5)
    wr(TCOU_ADDR_CNT_HI, 32'hFF);
    wr(TCOU_ADDR_CNT_LO, 32'hFE);
    ticks(7);
    `CHK(pin_value_o[0], 1'b1)
    ticks(1);
    `CHK(pin_value_o[0], 1'b0)
    give_verdict();
  end
endmodule
